//--- lacc_load_unit.sv
// Accumulator load-from-memory unit: decode, extend, shift, saturate, write
`timescale 1ns/1ps
`default_nettype none
`include "lacc_regs.svh"
module lacc_load_unit
  import lacc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic        instr_paired,
  input  wire logic [15:0] mem_data,
  input  wire logic [22:0] mem_addr,
  input  wire logic [15:0] temp_shift_0,
  input  wire logic [15:0] temp_shift_1,
  input  wire logic [15:0] temp_shift_2,
  input  wire logic [15:0] temp_shift_3,
  input  wire logic        sign_extension_mode,
  input  wire logic        wide_overflow_mode,
  input  wire logic        rounding_mode,
  input  wire logic        saturation_enable,
  input  wire logic        legacy_compat_mode,
  input  wire logic [3:0]  ovf_flag_clear,
  output logic             acc_write_valid,
  output logic [1:0]       dest_accumulator,
  output logic [39:0]      acc_write_data,
  output logic [3:0]       accumulator_overflow_flag,
  output logic             bus_error_interrupt,
  output logic             instr_refused
);
  lacc_form_type      form;
  logic [1:0]         dest;
  logic               rnd_q;
  logic               uns_q;
  logic [1:0]         tsel;
  logic [5:0]         imm_sh;
  logic [15:0]        tx_val;
  logic signed [5:0]  tx_amt;
  logic signed [5:0]  amt;
  logic [39:0]        ext_val;
  logic [79:0]        wide_val;
  logic [39:0]        sat_val;
  logic               ovf;
  logic               detect_en;
  logic               is_byte;
  logic               mmr_hit;
  logic               take;
  logic               do_write;
  logic [39:0]        write_next;
  logic               acc_write_valid_reg;
  logic [1:0]         dest_reg;
  logic [39:0]        acc_data_reg;
  logic [3:0]         flags_reg;
  logic [3:0]         flags_next;
  logic               berr_reg;
  logic               refused_reg;

  // Opcode decode; unlisted patterns give form_none and are ignored
  always_comb begin
    form   = form_none;
    dest   = '0;
    rnd_q  = 1'b0;
    uns_q  = 1'b0;
    tsel   = '0;
    imm_sh = `LACC_SH_ZERO;
    if (instr_word[`LACC_BYTE0] == `LACC_OP_RSH &&
        instr_word[`LACC_RSH_TAG] == `LACC_RSH_TAGV) begin
      form  = form_reg_shift;
      dest  = instr_word[`LACC_RSH_DD];
      rnd_q = instr_word[`LACC_RSH_RND];
      tsel  = instr_word[`LACC_RSH_TS];
    end else if (instr_word[`LACC_BYTE0] == `LACC_OP_LOB) begin
      form   = form_low_byte;
      dest   = instr_word[`LACC_BYTE_DD];
      imm_sh = instr_word[`LACC_BYTE_SH];
    end else if (instr_word[`LACC_BYTE0] == `LACC_OP_HIB) begin
      form   = form_high_byte;
      dest   = instr_word[`LACC_BYTE_DD];
      imm_sh = instr_word[`LACC_BYTE_SH];
    end else if (instr_word[`LACC_FIX_OP] == `LACC_OP_FIX) begin
      form = form_fixed16;
      dest = instr_word[`LACC_FIX_DD];
    end else if (instr_word[`LACC_BYTE0] == `LACC_OP_PLN &&
                 instr_word[`LACC_PLN_TAG] == `LACC_PLN_TAGV) begin
      form  = form_plain;
      dest  = instr_word[`LACC_PLN_DD];
      uns_q = instr_word[`LACC_PLN_U];
    end else if (instr_word[`LACC_BYTE0] == `LACC_OP_IMM &&
                 instr_word[`LACC_IMM_TAG] == `LACC_IMM_TAGV) begin
      form   = form_imm_shift;
      dest   = instr_word[`LACC_IMM_DD];
      uns_q  = instr_word[`LACC_IMM_U];
      imm_sh = instr_word[`LACC_IMM_SH];
    end
  end

  // Temporary register pick; only its six low bits count
  always_comb begin
    case (tsel)
      2'h0:    tx_val = temp_shift_0;
      2'h1:    tx_val = temp_shift_1;
      2'h2:    tx_val = temp_shift_2;
      default: tx_val = temp_shift_3;
    endcase
    tx_amt = tx_val[`LACC_SH_FIELD];
    // Legacy folds -32..-17 into -16..-1
    if (legacy_compat_mode && tx_val[`LACC_LEG_SEL] == `LACC_LEG_RANGE) begin
      tx_amt = tx_val[`LACC_SH_FIELD] + `LACC_LEG_ADJ;
    end
  end

  // Shift amount per form; plain form never reaches the shifter
  always_comb begin
    case (form)
      form_reg_shift: amt = tx_amt;
      form_fixed16:   amt = `LACC_FIX_SHIFT;
      form_low_byte,
      form_high_byte,
      form_imm_shift: amt = imm_sh;
      default:        amt = `LACC_SH_ZERO;
    endcase
  end

  // Operand widening; unsigned qualifier overrides the sign mode
  always_comb begin
    is_byte = (form == form_low_byte) || (form == form_high_byte);
    if (form == form_high_byte) begin
      ext_val = lacc_extend({8'h00, mem_data[`LACC_HIGH_BYTE]}, 1'b1,
                            sign_extension_mode);
    end else begin
      ext_val = lacc_extend(mem_data, is_byte,
                            sign_extension_mode & ~uns_q);
    end
  end

  // Overflow checking: fixed form always, other shifters only outside legacy
  always_comb begin
    case (form)
      form_fixed16:   detect_en = 1'b1;
      form_reg_shift,
      form_low_byte,
      form_high_byte,
      form_imm_shift: detect_en = ~legacy_compat_mode;
      default:        detect_en = 1'b0;
    endcase
  end

  // Shared signed shifter; rounding only with the round qualifier
  lacc_shifter u_shifter (
    .operand       (ext_val),
    .amount        (amt),
    .round_en      (rnd_q && form == form_reg_shift),
    .rounding_mode (rounding_mode),
    .wide_result   (wide_val)
  );

  // Width-aware overflow and clamp
  lacc_saturate u_saturate (
    .wide_value (wide_val),
    .wide_mode  (wide_overflow_mode),
    .detect_en  (detect_en),
    .sat_en     (saturation_enable),
    .result     (sat_val),
    .overflow   (ovf)
  );

  // Issue qualification; repeat iterations look like any other issue
  always_comb begin
    mmr_hit  = is_byte && (mem_addr < `LACC_MMR_LIMIT);
    take     = instr_valid && !instr_paired && form != form_none;
    do_write = take && !mmr_hit;
    // Plain form bypasses shifter and saturation
    write_next = (form == form_plain) ? ext_val : sat_val;
  end

  // Result register: one write per accepted issue, next cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_write_valid_reg <= 1'b0;
      dest_reg            <= '0;
      acc_data_reg        <= '0;
    end else begin
      acc_write_valid_reg <= do_write;
      if (do_write) begin
        dest_reg     <= dest;
        acc_data_reg <= write_next;
      end
    end
  end

  // Sticky overflow flags; a set in the clear cycle wins
  always_comb begin
    flags_next = flags_reg & ~ovf_flag_clear;
    if (do_write && ovf) begin
      flags_next[dest] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= `LACC_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Event pulses: bus error on a byte access to the register page,
  // refusal when a pairing is attempted
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      berr_reg    <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      berr_reg    <= take && mmr_hit;
      refused_reg <= instr_valid && instr_paired;
    end
  end

  assign acc_write_valid           = acc_write_valid_reg;
  assign dest_accumulator          = dest_reg;
  assign acc_write_data            = acc_data_reg;
  assign accumulator_overflow_flag = flags_reg;
  assign bus_error_interrupt       = berr_reg;
  assign instr_refused             = refused_reg;

  // Checks of the datapath against its issue conditions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_issue_ok;
    instr_valid && !instr_paired;
  endsequence

  sequence s_fixed_unsigned_big;
    s_issue_ok ##0 form == form_fixed16 && !sign_extension_mode &&
    !wide_overflow_mode && mem_data[15];
  endsequence

  sequence s_byte_to_mmr;
    s_issue_ok ##0 is_byte && mem_addr < `LACC_MMR_LIMIT;
  endsequence

  sequence s_write_slot;
    s_issue_ok ##0 form != form_none && !mmr_hit;
  endsequence

  a_single_cycle_write: assert property (
    s_issue_ok ##0 form != form_none && !mmr_hit |=> acc_write_valid
  ) else $error("accepted load did not write next cycle");

  a_pair_refused: assert property (
    instr_valid && instr_paired |=> instr_refused && !acc_write_valid
  ) else $error("paired load was not refused");

  a_mmr_bus_error: assert property (
    s_byte_to_mmr |=> bus_error_interrupt && !acc_write_valid
  ) else $error("byte load to register page not trapped");

  a_plain_flags_kept: assert property (
    s_issue_ok ##0 form == form_plain |=>
      accumulator_overflow_flag == ($past(flags_reg) & ~$past(ovf_flag_clear))
  ) else $error("plain load touched overflow flags");

  a_plain_zero_extend: assert property (
    s_issue_ok ##0 form == form_plain && uns_q |=>
      acc_write_data == {24'h000000, $past(mem_data)}
  ) else $error("unsigned plain load not zero extended");

  a_legacy_no_ovf: assert property (
    s_issue_ok ##0 legacy_compat_mode && form inside {form_reg_shift,
      form_low_byte, form_high_byte, form_imm_shift} |=>
      accumulator_overflow_flag == ($past(flags_reg) & ~$past(ovf_flag_clear))
  ) else $error("legacy shifted load reported overflow");

  a_fixed_ovf_flag: assert property (
    s_fixed_unsigned_big |=> accumulator_overflow_flag[dest_accumulator]
  ) else $error("fixed shift overflow not flagged");

  a_fixed_sat_value: assert property (
    s_fixed_unsigned_big ##0 saturation_enable |=>
      acc_write_data == `LACC_SAT_POS32
  ) else $error("fixed shift overflow not clamped");

  a_fixed_shift_value: assert property (
    s_issue_ok ##0 form == form_fixed16 && wide_overflow_mode &&
    sign_extension_mode |=> acc_write_data ==
      {{8{$past(mem_data[15])}}, $past(mem_data), 16'h0000}
  ) else $error("fixed form did not shift left by sixteen");

  a_low_byte_value: assert property (
    s_issue_ok ##0 form == form_low_byte && !mmr_hit && imm_sh == `LACC_SH_ZERO &&
    sign_extension_mode |=> acc_write_data ==
      {{32{$past(mem_data[7])}}, $past(mem_data[`LACC_LOW_BYTE])}
  ) else $error("low byte load value wrong");

  a_high_byte_value: assert property (
    s_issue_ok ##0 form == form_high_byte && !mmr_hit && imm_sh == `LACC_SH_ZERO &&
    !sign_extension_mode |=> acc_write_data ==
      {32'h00000000, $past(mem_data[`LACC_HIGH_BYTE])}
  ) else $error("high byte load value wrong");

  a_legacy_fold: assert property (
    form == form_reg_shift && legacy_compat_mode &&
    tx_val[`LACC_LEG_SEL] == `LACC_LEG_RANGE |-> tx_amt < 0 && tx_amt >= -16
  ) else $error("legacy shift amount not folded");

  // Pulses stay low unless their own cause was seen in the cycle before
  a_berr_pulse_only: assert property (
    !(take && mmr_hit) |=> !bus_error_interrupt
  ) else $error("bus error without a trapped byte load");

  a_refuse_pulse_only: assert property (
    !(instr_valid && instr_paired) |=> !instr_refused
  ) else $error("refusal without a paired issue");

  // No write slot opens on its own
  a_write_needs_issue: assert property (
    !(instr_valid && !instr_paired && form != form_none && !mmr_hit) |=> !acc_write_valid
  ) else $error("write without an accepted load");

  a_dest_follows: assert property (
    s_write_slot |=> dest_accumulator == $past(dest)
  ) else $error("write went to the wrong accumulator");

  // The flag set must survive a clear raised in the same cycle
  a_ovf_set_wins: assert property (
    s_write_slot ##0 ovf |=> accumulator_overflow_flag[dest_accumulator]
  ) else $error("overflow flag lost on write");

  // Rounding clears the fraction unless a clamp replaced the value
  a_round_low_clear: assert property (
    s_write_slot ##0 form == form_reg_shift && rnd_q && !(ovf && saturation_enable) |=>
      acc_write_data[`LACC_RND_LOW] == '0
  ) else $error("rounded load kept low bits");

  a_plain_sign_extend: assert property (
    s_issue_ok ##0 form == form_plain && !uns_q && sign_extension_mode |=>
      acc_write_data == {{24{$past(mem_data[15])}}, $past(mem_data)}
  ) else $error("signed plain load not sign extended");
endmodule
`default_nettype wire

//--- lacc_regs.svh
// Constants and field layout of the accumulator load-from-memory datapath
// Function
// - Every load form completes in one cycle and refuses parallel pairing.
// - Only the six low temporary register bits give the shift, -32 to +31.
// - Legacy mode turns register shifts of -32 to -17 into modulo 16 shifts.
// - Round qualifier rounds the register-shifted result using the rounding mode.
// - Shifted forms extend to 40 bits per sign mode, then shift signed.
// - Legacy mode disables overflow check and saturation for register, byte, immediate shifts.
// - Low-byte form loads low byte, sign-mode extended, shifted by 6-bit immediate.
// - High-byte form loads high byte, sign-mode extended, shifted by 6-bit immediate.
// - Byte form on memory-mapped register skips the load and raises bus error.
// - Fixed form 1011 00DD shifts left by 16 under overflow width mode.
// - Fixed form keeps overflow check and saturation after shifting even in legacy.
// - Unsigned qualifier zero-extends operand in plain and immediate-shift forms.
// - Without unsigned qualifier those forms extend according to the sign mode.
// - Plain form xxDD 010u bypasses shifter and leaves overflow flags alone.
// - Form 1111 1001 shifts optionally unsigned operand by 6-bit immediate.
// - Shifting forms set destination overflow flag as the four modes dictate.
`ifndef LACC_REGS_SVH
`define LACC_REGS_SVH
// Opcode bytes and field slices, first byte in bits 31:24
`define LACC_BYTE0       31:24
`define LACC_OP_RSH      8'hDD
`define LACC_OP_LOB      8'hE1
`define LACC_OP_HIB      8'hE2
`define LACC_OP_PLN      8'hDF
`define LACC_OP_IMM      8'hF9
`define LACC_FIX_OP      31:26
`define LACC_OP_FIX      6'h2C
`define LACC_FIX_DD      25:24
`define LACC_RSH_RND     14
`define LACC_RSH_DD      13:12
`define LACC_RSH_TS      11:10
`define LACC_RSH_TAG     9:8
`define LACC_RSH_TAGV    2'h3
`define LACC_BYTE_DD     15:14
`define LACC_BYTE_SH     13:8
`define LACC_PLN_DD      13:12
`define LACC_PLN_TAG     11:9
`define LACC_PLN_TAGV    3'h2
`define LACC_PLN_U       8
`define LACC_IMM_U       15
`define LACC_IMM_SH      13:8
`define LACC_IMM_DD      5:4
`define LACC_IMM_TAG     3:2
`define LACC_IMM_TAGV    2'h2
// Shift amounts and data slices
`define LACC_SH_FIELD    5:0
`define LACC_SH_ZERO     6'h00
`define LACC_FIX_SHIFT   6'h10
`define LACC_LEG_SEL     5:4
`define LACC_LEG_RANGE   2'h2
`define LACC_LEG_ADJ     6'h10
`define LACC_LOW_BYTE    7:0
`define LACC_HIGH_BYTE   15:8
`define LACC_MMR_LIMIT   23'h000060
// Rounding, overflow and saturation
`define LACC_RND_ADD     80'h0000_0000_0000_0000_8000
`define LACC_RND_HALF    16'h8000
`define LACC_RND_LOW     15:0
`define LACC_RND_EVEN    16
`define LACC_OVF_NARROW  79:31
`define LACC_OVF_WIDE    79:39
`define LACC_WIDE_MSB    79
`define LACC_ACC_BITS    39:0
`define LACC_SAT_POS32   40'h007FFFFFFF
`define LACC_SAT_NEG32   40'hFF80000000
`define LACC_SAT_POS40   40'h7FFFFFFFFF
`define LACC_SAT_NEG40   40'h8000000000
`define LACC_FLAGS_RST   4'h0
`endif

//--- lacc_pkg.sv
// Types and shared helpers of the accumulator load datapath
package lacc_pkg;
  typedef enum logic [2:0] {
    form_none, form_reg_shift, form_low_byte, form_high_byte,
    form_fixed16, form_plain, form_imm_shift
  } lacc_form_type;

  // Operand widening: byte or word, signed or zero filled
  function automatic logic [39:0] lacc_extend(input logic [15:0] val,
                                              input logic        is_byte,
                                              input logic        sgn);
    logic fill;
    fill = 1'b0;
    if (is_byte) begin
      fill = sgn & val[7];
      return {{32{fill}}, val[7:0]};
    end
    fill = sgn & val[15];
    return {{24{fill}}, val};
  endfunction
endpackage

//--- lacc_shifter.sv
// Signed shifter with optional rounding at bit 15
`timescale 1ns/1ps
`default_nettype none
`include "lacc_regs.svh"
module lacc_shifter
  import lacc_pkg::*;
(
  input  wire logic        [39:0] operand,
  input  wire logic signed [5:0]  amount,
  input  wire logic               round_en,
  input  wire logic               rounding_mode,
  output logic             [79:0] wide_result
);
  logic signed [79:0] ext;
  logic signed [79:0] shifted;
  logic        [6:0]  mag;

  // Positive amounts shift left, negative ones shift right arithmetically
  always_comb begin
    ext     = {{40{operand[39]}}, operand};
    mag     = 7'(-{amount[5], amount});
    shifted = (amount >= 0) ? (ext <<< amount) : (ext >>> mag);
  end

  // Round to the high part; unbiased mode breaks exact ties toward even
  always_comb begin
    wide_result = shifted;
    if (round_en) begin
      wide_result = shifted + `LACC_RND_ADD;
      if (rounding_mode && shifted[`LACC_RND_LOW] == `LACC_RND_HALF) begin
        wide_result[`LACC_RND_EVEN] = 1'b0;
      end
      wide_result[`LACC_RND_LOW] = '0;
    end
  end
endmodule
`default_nettype wire

//--- lacc_saturate.sv
// Overflow detection and clamping at 32 or 40 bits
`timescale 1ns/1ps
`default_nettype none
`include "lacc_regs.svh"
module lacc_saturate
  import lacc_pkg::*;
(
  input  wire logic [79:0] wide_value,
  input  wire logic        wide_mode,
  input  wire logic        detect_en,
  input  wire logic        sat_en,
  output logic      [39:0] result,
  output logic             overflow
);
  logic narrow_ovf;
  logic wide_ovf;
  logic neg;

  // Overflow when the bits above the active sign bit disagree
  always_comb begin
    narrow_ovf = !((&wide_value[`LACC_OVF_NARROW]) || !(|wide_value[`LACC_OVF_NARROW]));
    wide_ovf   = !((&wide_value[`LACC_OVF_WIDE]) || !(|wide_value[`LACC_OVF_WIDE]));
    neg        = wide_value[`LACC_WIDE_MSB];
    overflow   = detect_en & (wide_mode ? wide_ovf : narrow_ovf);
    result     = wide_value[`LACC_ACC_BITS];
    if (overflow && sat_en) begin
      if (wide_mode) begin
        result = neg ? `LACC_SAT_NEG40 : `LACC_SAT_POS40;
      end else begin
        result = neg ? `LACC_SAT_NEG32 : `LACC_SAT_POS32;
      end
    end
  end
endmodule
`default_nettype wire

//--- lacc_mem_model.sv
// Data memory partner model: one sixteen-bit word per issue
`timescale 1ns/1ps
`default_nettype none
module lacc_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rd_en,
  input  wire logic [22:0] rd_addr,
  output logic      [15:0] rd_data
);
  logic [15:0] mem_reg [0:255];
  logic [15:0] last_reg;

  // Known start so the unit never sees an unknown operand line
  initial begin
    last_reg = 16'h5A5A;
    for (int i = 0; i < 256; i++) begin
      mem_reg[i] = 16'(i);
    end
  end

  // Outside an issue the line shows the inverse of the last word, never a stale copy
  always_comb begin
    if (rd_en) begin
      rd_data = mem_reg[rd_addr[7:0]];
    end else begin
      rd_data = ~last_reg;
    end
  end

  // Remember the word last handed over
  always @(posedge ref_clk) begin
    if (rd_en) begin
      last_reg <= rd_data;
    end
  end

  // Preload from the bench; only the low address byte is kept
  task automatic put(input logic [22:0] a, input logic [15:0] d);
    mem_reg[a[7:0]] = d;
  endtask
endmodule
`default_nettype wire

//--- lacc_load_unit_tb.sv
// Self-checking bench for the accumulator load-from-memory unit
`timescale 1ns/1ps
`default_nettype none
module lacc_load_unit_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        instr_valid = 1'b0;
  logic        instr_paired = 1'b0;
  logic [31:0] instr_word = 32'h0;
  logic [22:0] mem_addr = 23'h0;
  logic [15:0] mem_data;
  logic [15:0] tshift [0:3] = '{16'hFFC3, 16'h00FC, 16'h12EC, 16'hAA1F};
  logic [4:0]  mode_in = 5'h0;
  logic [3:0]  ovf_flag_clear = 4'h0;
  logic        acc_write_valid;
  logic [1:0]  dest_accumulator;
  logic [39:0] acc_write_data;
  logic [3:0]  accumulator_overflow_flag;
  logic        bus_error_interrupt;
  logic        instr_refused;
  // Mode order: legacy, saturation, rounding, wide, sign extension
  logic [4:0]  md = 5'h0;
  logic [3:0]  exp_flags = 4'h0;
  logic        pair_sel = 1'b0;
  int          error_cnt = 0;
  int          compares = 0;

  always #12.5 ref_clk = ~ref_clk;

  lacc_mem_model mem (.ref_clk(ref_clk), .rd_en(instr_valid), .rd_addr(mem_addr), .rd_data(mem_data));

  lacc_load_unit dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_paired(instr_paired), .mem_data(mem_data), .mem_addr(mem_addr),
    .temp_shift_0(tshift[0]), .temp_shift_1(tshift[1]), .temp_shift_2(tshift[2]), .temp_shift_3(tshift[3]),
    .sign_extension_mode(mode_in[0]), .wide_overflow_mode(mode_in[1]), .rounding_mode(mode_in[2]),
    .saturation_enable(mode_in[3]), .legacy_compat_mode(mode_in[4]), .ovf_flag_clear(ovf_flag_clear),
    .acc_write_valid(acc_write_valid), .dest_accumulator(dest_accumulator), .acc_write_data(acc_write_data),
    .accumulator_overflow_flag(accumulator_overflow_flag), .bus_error_interrupt(bus_error_interrupt),
    .instr_refused(instr_refused)
  );

  task automatic conclude();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Forms: 1 reg shift, 2 low byte, 3 high byte, 4 fixed, 5 plain, 6 immediate; sh[1:0] picks Tx
  function automatic logic [31:0] word_of(input int f, input logic [1:0] dd, input logic [5:0] sh,
                                          input logic u, input logic rnd);
    case (f)
      1: return {8'hDD, 8'h00, 1'b0, rnd, dd, sh[1:0], 2'b11, 8'h00};
      2: return {8'hE1, 8'h00, dd, sh, 8'h00};
      3: return {8'hE2, 8'h00, dd, sh, 8'h00};
      4: return {6'b101100, dd, 24'h000000};
      5: return {8'hDF, 8'h00, 2'b00, dd, 3'b010, u, 8'h00};
      default: return {8'hF9, 8'h00, u, 1'b0, sh, 2'b00, dd, 2'b10, 2'b00};
    endcase
  endfunction

  // Reference result: overflow-set bit on top of the 40-bit value
  function automatic logic [40:0] expect_load(input int f, input logic [15:0] d, input logic [5:0] sh,
                                              input logic u, input logic rnd);
    logic [39:0]        ext;
    logic signed [79:0] w;
    logic signed [6:0]  a;
    logic               byt;
    logic               tie;
    logic               ov;
    byt = (f == 2) || (f == 3);
    ext = byt ? {32'h0, (f == 2) ? d[7:0] : d[15:8]} : {24'h0, d};
    if (!u && md[0] && (byt ? ext[7] : ext[15])) ext = ext | (byt ? 40'hFFFFFFFF00 : 40'hFFFFFF0000);
    if (f == 5) return {1'b0, ext};
    a = (f == 4) ? 7'sd16 : {sh[5], sh};
    if (f == 1 && md[4] && sh[5:4] == 2'b10) a = a + 7'sd16;
    w = {{40{ext[39]}}, ext};
    if (a[6]) w = w >>> (-a);
    else w = w <<< a;
    if (rnd) begin
      tie = (w[15:0] == 16'h8000);
      w = w + 80'h8000;
      w[15:0] = 16'h0;
      if (tie && md[2]) w[16] = 1'b0;
    end
    ov = md[1] ? (w[79:39] != {41{w[79]}}) : (w[79:31] != {49{w[79]}});
    ov = ov && ((f == 4) || !md[4]);
    if (ov && md[3]) w[39:0] = w[79] ? (md[1] ? 40'h8000000000 : 40'hFF80000000)
                                     : (md[1] ? 40'h7FFFFFFFFF : 40'h007FFFFFFF);
    return {ov, w[39:0]};
  endfunction

  // One issue, then the answer one edge later
  task automatic issue(input int f, input logic [1:0] dd, input logic [15:0] d, input logic [5:0] sh,
                       input logic u, input logic rnd, input logic [22:0] a);
    logic [40:0] e;
    mem.put(a, d);
    @(posedge ref_clk);
    instr_word   <= word_of(f, dd, sh, u, rnd);
    instr_valid  <= 1'b1;
    instr_paired <= pair_sel;
    mem_addr     <= a;
    mode_in      <= md;
    @(posedge ref_clk);
    instr_valid  <= 1'b0;
    instr_paired <= 1'b0;
    #1;
    e = expect_load(f, d, (f == 1) ? tshift[sh[1:0]][5:0] : sh, u, rnd);
    if (pair_sel) begin
      check(instr_refused, 1'b1);
      check(acc_write_valid, 1'b0);
    end else if (a < 23'h000060 && (f == 2 || f == 3)) begin
      check(bus_error_interrupt, 1'b1);
      check(acc_write_valid, 1'b0);
    end else begin
      check(acc_write_valid, 1'b1);
      check(dest_accumulator, dd);
      check(acc_write_data, e[39:0]);
      if (e[40]) exp_flags[dd] = 1'b1;
    end
    check(accumulator_overflow_flag, exp_flags);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    conclude();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    check(acc_write_valid, 1'b0);
    check(accumulator_overflow_flag, 4'h0);
    check(acc_write_data, 40'h0);
    // Worked example of the fixed form
    md = 5'b00011;
    issue(4, 2'd0, 16'h1234, 6'h00, 1'b0, 1'b0, 23'h000080);
    check(acc_write_data, 40'h0012340000);
    // Fixed form across width, saturation and legacy; legacy runs keep wide mode low
    for (int k = 0; k < 8; k++) begin
      md = {k[2], k[1], 1'b0, k[0] & ~k[2], 1'b0};
      issue(4, 2'(k), 16'h8000, 6'h00, 1'b0, 1'b0, 23'h000081);
    end
    // Register shift: all temporaries, rounding modes, legacy fold
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 8; k++) begin
        md = {k[2], 1'b1, k[1], 1'b0, 1'b1};
        issue(1, 2'(t), (t == 1) ? 16'hF123 : 16'h1000, 6'(t), 1'b0, k[0], 23'h000082);
      end
    end
    // Byte forms, then the register page boundary
    for (int b = 2; b < 4; b++) begin
      for (int k = 0; k < 8; k++) begin
        md = {k[2], 1'b1, 1'b0, k[1] & ~k[2], k[0]};
        issue(b, 2'(k), 16'h80F1, k[1] ? 6'h00 : (k[0] ? 6'd31 : 6'h3F), 1'b0, 1'b0, 23'h000083);
      end
      issue(b, 2'd1, 16'h7F7F, 6'd1, 1'b0, 1'b0, 23'h00005F);
      issue(b, 2'd1, 16'h7F7F, 6'd1, 1'b0, 1'b0, 23'h000060);
    end
    // Plain and immediate forms with and without the unsigned qualifier
    for (int k = 0; k < 8; k++) begin
      md = {k[2], 1'b1, 1'b0, 1'b0, k[1]};
      issue(5, 2'(k), 16'h8001, 6'h00, k[0], 1'b0, 23'h000084);
      issue(6, 2'(k), 16'hC000, k[1] ? 6'h20 : 6'd31, k[0], 1'b0, 23'h000085);
    end
    // Paired issue is turned away
    pair_sel = 1'b1;
    issue(4, 2'd3, 16'h8000, 6'h00, 1'b0, 1'b0, 23'h000086);
    pair_sel = 1'b0;
    // Clear held while a new overflow lands: the new one must survive
    @(posedge ref_clk);
    ovf_flag_clear <= 4'hF;
    exp_flags = 4'h0;
    md = 5'b01000;
    issue(4, 2'd2, 16'h8000, 6'h00, 1'b0, 1'b0, 23'h000087);
    @(posedge ref_clk);
    ovf_flag_clear <= 4'h0;
    // Back-to-back issues as in a repeat loop, ending with an unknown opcode
    md = 5'b00011;
    for (int i = 0; i < 3; i++) begin
      mem.put(23'(8'h90 + i), 16'(16'h1111 * (i + 1)));
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr_word  <= (i < 3) ? 32'hB100_0000 : 32'h0000_0000;
      mem_addr    <= 23'(8'h90 + i);
      mode_in     <= md;
      #1;
      if (i > 0) begin
        check(acc_write_valid, 1'b1);
        check(acc_write_data, {8'h00, 16'(16'h1111 * i), 16'h0000});
      end
    end
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    check(acc_write_valid, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
